// file: rtl/span_cal_common.sv
// Shared constants for the span calibrator and its restoring divider
package span_cal_pkg;
   // Sizes
   localparam int NUM_SPANS = 8;
   localparam int NUM_AUX = 5;
   localparam int NUM_RELAYS = 5;
   localparam int NUM_MA = 2;
   localparam int SPAN_W = 16;
   localparam int DIV_W = 48;
   // APB byte offsets
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_AUX_FUNC = 12'h004;
   localparam logic [11:0] OFS_SPAN_SEL = 12'h008;
   localparam logic [11:0] OFS_REF_WT = 12'h00C;
   localparam logic [11:0] OFS_LIMITS = 12'h010;
   localparam logic [11:0] OFS_MA_CAL = 12'h014;
   localparam logic [11:0] OFS_MA_FUNC = 12'h018;
   localparam logic [11:0] OFS_RELAY_FUNC = 12'h01C;
   localparam logic [11:0] OFS_RELAY_POL = 12'h020;
   localparam logic [11:0] OFS_CMD = 12'h024;
   localparam logic [11:0] OFS_STATUS = 12'h028;
   localparam logic [11:0] OFS_TOTAL = 12'h02C;
   localparam logic [11:0] OFS_DEVIATION = 12'h030;
   localparam logic [11:0] OFS_NEW_SPAN = 12'h034;
   localparam logic [11:0] OFS_LIN_GAIN = 12'h038;
   localparam logic [11:0] OFS_SPAN_BASE = 12'h040;
   localparam logic [11:0] OFS_INIT_BASE = 12'h060;
   localparam logic [11:0] OFS_TABLE_MASK = 12'hFE3;
   // Field positions
   localparam int LIM_MAX_LSB = 0;
   localparam int LIM_HIGH_LSB = 10;
   localparam int LIM_LOW_LSB = 20;
   localparam int LIM_W = 10;
   localparam int MA_HI_LSB = 16;
   localparam int CMD_ACTIVATE = 0;
   localparam int CMD_ACCEPT = 1;
   localparam int CMD_RUN = 2;
   localparam int CMD_REARM = 3;
   // Reset values, limits in tenths of a percent
   localparam logic [9:0] MAX_RST = 10'h384;
   localparam logic [9:0] HIGH_RST = 10'h2BC;
   localparam logic [9:0] LOW_RST = 10'h12C;
   localparam logic [15:0] MA_LO_RST = 16'h0000;
   localparam logic [15:0] MA_HI_RST = 16'hFFFF;
   localparam logic [3:0] SPAN_NUM_RST = 4'h1;
   localparam logic [15:0] SPAN_RST = 16'h8000;
   localparam logic [31:0] LIN_UNITY = 32'h0001_0000;
   // Function codes
   localparam logic [1:0] MA_FUNC_ONLINE = 2'h3;
   localparam logic [3:0] RELAY_FUNC_ONLINE = 4'h9;
   localparam logic [3:0] AUX_SPAN_SEL = 4'h1;
   localparam logic [3:0] AUX_ACTIVATE = 4'h2;
   localparam logic [3:0] AUX_ACCEPT = 4'h3;
   localparam logic [3:0] AUX_RUN = 4'h4;
   // Arithmetic scales
   localparam logic [15:0] PCT_SCALE = 16'h03E8;
   localparam logic [7:0] HUNDRED = 8'h64;
   localparam logic [7:0] DEV_LIMIT_PCT = 8'h0C;
   localparam int SPAN_SHIFT = 15;
   localparam int LIN_SHIFT = 16;
   // Online check sequencer, Gray from idle through to result; the return to idle flips two bits
   typedef enum logic [2:0] {
      S_IDLE = 3'h0,
      S_FILL = 3'h1,
      S_WAIT_HIGH = 3'h3,
      S_TOTAL = 3'h2,
      S_DIV_DEV = 3'h6,
      S_DIV_SPAN = 3'h7,
      S_RESULT = 3'h5
   } cal_state_type;
   typedef enum logic [1:0] {
      T_LEVEL = 2'h0,
      T_DEV = 2'h1,
      T_SPAN = 2'h2
   } div_tag_type;
endpackage : span_cal_pkg

`timescale 1ns/10ps
`default_nettype none
// Unsigned restoring divider, one quotient bit per clock
module div_unit #(
   parameter int W = 48
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start,
   input wire logic [W-1:0] num,
   input wire logic [W-1:0] den,
   output logic busy,
   output logic done,
   output logic [W-1:0] quo
);
   logic [W-1:0] rem_q, rem_d, quo_q, quo_d, den_q, den_d;
   logic [$clog2(W+1)-1:0] cnt_q, cnt_d;
   logic busy_q, busy_d, done_q, done_d;
   logic [W:0] trial;

   // One shift-subtract step; a zero divisor yields all ones
   always_comb begin
      rem_d = rem_q;
      quo_d = quo_q;
      den_d = den_q;
      cnt_d = cnt_q;
      busy_d = busy_q;
      done_d = 1'b0;
      trial = {rem_q, quo_q[W-1]} - {1'b0, den_q};
      if (start && !busy_q) begin
         rem_d = '0;
         quo_d = num;
         den_d = den;
         cnt_d = ($clog2(W+1))'(W);
         busy_d = 1'b1;
      end else if (busy_q) begin
         if (!trial[W]) begin
            rem_d = trial[W-1:0];
            quo_d = {quo_q[W-2:0], 1'b1};
         end else begin
            rem_d = {rem_q[W-2:0], quo_q[W-1]};
            quo_d = {quo_q[W-2:0], 1'b0};
         end
         cnt_d = cnt_q - 1'b1;
         if (cnt_q == 1) begin
            busy_d = 1'b0;
            done_d = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rem_q <= '0;
         quo_q <= '0;
         den_q <= '0;
         cnt_q <= '0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         rem_q <= rem_d;
         quo_q <= quo_d;
         den_q <= den_d;
         cnt_q <= cnt_d;
         busy_q <= busy_d;
         done_q <= done_d;
      end
   end

   assign busy = busy_q;
   assign done = done_q;
   assign quo = quo_q;
endmodule : div_unit
`default_nettype wire

// file: rtl/span_calibrator.sv
// Multispan selection and online span-check sequencer with APB registers
// Function
// - Eight span counts; selected one scales rate
// - Remote contact selection overrides keypad selection
// - First aux input alone picks span 1-2
// - Aux 1 and 2 pick spans 1-4
// - Aux 1, 2, 3 pick spans 1-8
// - Remote selection locked until span calibrated
// - Linearization gain applies to every span
// - Enable setting 0/1 gates activation
// - Store max, high, low level percentages
// - Empty reading is 4 mA, full 20 mA
// - Analog function code 3 feeds bin level
// - Any of five relays, code 9, polarity
// - Report level until maximum reached
// - Energize relay at maximum level
// - Start online totalizer at high level
// - At low level stop totalizer, release relay
// - Compare total to reference; show deviation, span
// - Refuse results beyond 12 percent of initial
// - Activate, accept, run also by contacts
// - Reject discards; return run or re-arm
`timescale 1ns/10ps
`default_nettype none
module span_calibrator
   import span_cal_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [span_cal_pkg::NUM_AUX-1:0] aux_in,
   input wire logic [15:0] ma_in_0,
   input wire logic [15:0] ma_in_1,
   input wire logic [15:0] rate_in,
   input wire logic rate_valid,
   output logic [31:0] rate_out,
   output logic rate_out_valid,
   output logic [span_cal_pkg::NUM_RELAYS-1:0] relay_out
);
   import span_cal_pkg::*;

   // Contact synchronisers
   logic [NUM_AUX-1:0] s1_q, s2_q, s3_q, filt_q, filt_d, filt_prev_q;
   always_comb begin
      filt_d = filt_q;
      for (int i = 0; i < NUM_AUX; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            filt_d[i] = s3_q[i];
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         filt_q <= '0;
         filt_prev_q <= '0;
      end else begin
         s1_q <= aux_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         filt_q <= filt_d;
         filt_prev_q <= filt_q;
      end
   end

   // Per-input function decode and closing-edge triggers
   logic [NUM_AUX-1:0] aux_is_span, aux_act, aux_acc, aux_run;
   logic [4*NUM_AUX-1:0] aux_func_q, aux_func_d;
   genvar g;
   generate
      for (g = 0; g < NUM_AUX; g++) begin : g_aux
         logic [3:0] fn;
         logic rise;
         assign fn = aux_func_q[4*g +: 4];
         assign rise = filt_q[g] && !filt_prev_q[g];
         assign aux_is_span[g] = (fn == AUX_SPAN_SEL);
         assign aux_act[g] = rise && (fn == AUX_ACTIVATE);
         assign aux_acc[g] = rise && (fn == AUX_ACCEPT);
         assign aux_run[g] = rise && (fn == AUX_RUN);
      end
   endgenerate

   // Configuration and calibration storage
   logic enable_q, enable_d, span_done_q, span_done_d;
   logic [3:0] span_num_q, span_num_d;
   logic [31:0] ref_wt_q, ref_wt_d, lin_gain_q, lin_gain_d;
   logic [9:0] max_q, max_d, high_q, high_d, low_q, low_d;
   logic [15:0] ma_lo_q, ma_lo_d, ma_hi_q, ma_hi_d;
   logic [2*NUM_MA-1:0] ma_func_q, ma_func_d;
   logic [4*NUM_RELAYS-1:0] relay_func_q, relay_func_d;
   logic [NUM_RELAYS-1:0] relay_pol_q, relay_pol_d;
   logic [SPAN_W-1:0] span_tab_q [NUM_SPANS];
   logic [SPAN_W-1:0] span_tab_d [NUM_SPANS];
   logic [SPAN_W-1:0] init_tab_q [NUM_SPANS];
   logic [SPAN_W-1:0] init_tab_d [NUM_SPANS];

   // Sequencer state
   cal_state_type state_q, state_d;
   div_tag_type tag_q, tag_d;
   logic [31:0] total_q, total_d;
   logic [15:0] dev_q, dev_d, level_q, level_d, new_span_q, new_span_d;
   logic dev_neg_q, dev_neg_d, oor_q, oor_d, relay_on_q, relay_on_d;

   // APB slave, one wait state so read data comes from a flop
   logic [31:0] prdata_q, prdata_d, rd_mux;
   logic pready_q, pready_d, pslverr_q, pslverr_d, mapped;
   logic wr_en, cmd_act, cmd_acc, cmd_run, cmd_rearm, tab_hit, init_hit;
   logic [2:0] tab_idx;
   assign tab_hit = (paddr & OFS_TABLE_MASK) == OFS_SPAN_BASE;
   assign init_hit = (paddr & OFS_TABLE_MASK) == OFS_INIT_BASE;
   assign tab_idx = paddr[4:2];
   assign wr_en = psel && penable && pready_q && pwrite && !pslverr_q;
   assign cmd_act = wr_en && (paddr == OFS_CMD) && pwdata[CMD_ACTIVATE];
   assign cmd_acc = wr_en && (paddr == OFS_CMD) && pwdata[CMD_ACCEPT];
   assign cmd_run = wr_en && (paddr == OFS_CMD) && pwdata[CMD_RUN];
   assign cmd_rearm = wr_en && (paddr == OFS_CMD) && pwdata[CMD_REARM];

   // Span selection: keypad number, overridden by contacts once calibrated
   logic [2:0] key_idx, remote_idx, span_idx;
   logic remote_on;
   assign key_idx = 3'(span_num_q - 4'h1);
   assign remote_on = span_done_q && aux_is_span[0];
   assign remote_idx = {filt_q[2] && aux_is_span[2] && aux_is_span[1],
                        filt_q[1] && aux_is_span[1],
                        filt_q[0]};
   assign span_idx = remote_on ? remote_idx : key_idx;
   logic [SPAN_W-1:0] span_cur, span_init;
   assign span_cur = span_tab_q[span_idx];
   assign span_init = init_tab_q[span_idx];

   always_comb begin
      mapped = 1'b1;
      rd_mux = '0;
      if (tab_hit) rd_mux = {16'h0000, span_tab_q[tab_idx]};
      else if (init_hit) rd_mux = {16'h0000, init_tab_q[tab_idx]};
      else begin
         case (paddr)
            OFS_CTRL: rd_mux = {31'h0, enable_q};
            OFS_AUX_FUNC: rd_mux = 32'(aux_func_q);
            OFS_SPAN_SEL: rd_mux = {28'h0, span_num_q};
            OFS_REF_WT: rd_mux = ref_wt_q;
            OFS_LIMITS: rd_mux = {2'h0, low_q, high_q, max_q};
            OFS_MA_CAL: rd_mux = {ma_hi_q, ma_lo_q};
            OFS_MA_FUNC: rd_mux = 32'(ma_func_q);
            OFS_RELAY_FUNC: rd_mux = 32'(relay_func_q);
            OFS_RELAY_POL: rd_mux = 32'(relay_pol_q);
            OFS_CMD: rd_mux = '0;
            OFS_STATUS: rd_mux = {level_q, 5'h0, span_idx, 1'b0, remote_on, relay_on_q,
                                  span_done_q, oor_q, state_q};
            OFS_TOTAL: rd_mux = total_q;
            OFS_DEVIATION: rd_mux = {dev_neg_q, 15'h0, dev_q};
            OFS_NEW_SPAN: rd_mux = {16'h0000, new_span_q};
            OFS_LIN_GAIN: rd_mux = lin_gain_q;
            default: mapped = 1'b0;
         endcase
      end
      pready_d = psel && penable && !pready_q;
      prdata_d = pready_d ? rd_mux : prdata_q;
      pslverr_d = pready_d && !mapped;
   end

   // Bin level scaling: empty reading to full reading, tenths of percent
   logic [15:0] ma_sel;
   logic [DIV_W-1:0] div_num, div_den, div_quo;
   logic div_start, div_busy, div_done;
   logic [31:0] dev_abs;
   assign ma_sel = (ma_func_q[3:2] == MA_FUNC_ONLINE) ? ma_in_1 : ma_in_0;
   assign dev_abs = (total_q >= ref_wt_q) ? total_q - ref_wt_q : ref_wt_q - total_q;
   always_comb begin
      case (state_q)
         S_DIV_DEV: begin
            div_num = DIV_W'(dev_abs) * DIV_W'(PCT_SCALE);
            div_den = DIV_W'(ref_wt_q);
         end
         S_DIV_SPAN: begin
            div_num = DIV_W'(span_cur) * DIV_W'(total_q);
            div_den = DIV_W'(ref_wt_q);
         end
         default: begin
            div_num = (ma_sel > ma_lo_q) ? DIV_W'(ma_sel - ma_lo_q) * DIV_W'(PCT_SCALE) : '0;
            div_den = DIV_W'(ma_hi_q - ma_lo_q);
         end
      endcase
   end
   assign div_start = !div_busy;

   div_unit #(.W(DIV_W)) u_div (
      .pclk(pclk),
      .presetn(presetn),
      .start(div_start),
      .num(div_num),
      .den(div_den),
      .busy(div_busy),
      .done(div_done),
      .quo(div_quo)
   );

   // Rate scaled by the selected span, then by the common linearization gain
   logic [31:0] rate_span, rate_d, rate_q;
   logic [63:0] rate_lin;
   logic rate_v_q;
   assign rate_span = 32'((32'(rate_in) * 32'(span_cur)) >> SPAN_SHIFT);
   assign rate_lin = 64'(rate_span) * 64'(lin_gain_q);
   assign rate_d = rate_valid ? rate_lin[LIN_SHIFT +: 32] : rate_q;

   // Result range test against the initial span
   logic oor_calc;
   logic [31:0] span_diff;
   assign span_diff = (new_span_q >= span_init) ? 32'(new_span_q - span_init) : 32'(span_init - new_span_q);
   assign oor_calc = span_diff * 32'(HUNDRED) > 32'(span_init) * 32'(DEV_LIMIT_PCT);

   logic accept_req, run_req, act_req;
   assign accept_req = cmd_acc || (|aux_acc);
   assign run_req = cmd_run || (|aux_run);
   assign act_req = cmd_act || (|aux_act);

   // Sequencer and register writes
   always_comb begin
      enable_d = enable_q;
      aux_func_d = aux_func_q;
      span_num_d = span_num_q;
      ref_wt_d = ref_wt_q;
      lin_gain_d = lin_gain_q;
      max_d = max_q;
      high_d = high_q;
      low_d = low_q;
      ma_lo_d = ma_lo_q;
      ma_hi_d = ma_hi_q;
      ma_func_d = ma_func_q;
      relay_func_d = relay_func_q;
      relay_pol_d = relay_pol_q;
      span_tab_d = span_tab_q;
      init_tab_d = init_tab_q;
      span_done_d = span_done_q;
      state_d = state_q;
      tag_d = div_start ? ((state_q == S_DIV_DEV) ? T_DEV : (state_q == S_DIV_SPAN) ? T_SPAN : T_LEVEL) : tag_q;
      total_d = total_q;
      dev_d = dev_q;
      dev_neg_d = dev_neg_q;
      new_span_d = new_span_q;
      level_d = (div_done && tag_q == T_LEVEL) ? div_quo[15:0] : level_q;
      oor_d = oor_q;
      relay_on_d = relay_on_q;
      if (wr_en) begin
         if (tab_hit) begin
            span_tab_d[tab_idx] = pwdata[SPAN_W-1:0];
            init_tab_d[tab_idx] = pwdata[SPAN_W-1:0];
            span_done_d = 1'b1;
         end
         case (paddr)
            OFS_CTRL: enable_d = pwdata[0];
            OFS_AUX_FUNC: aux_func_d = pwdata[4*NUM_AUX-1:0];
            OFS_SPAN_SEL: if (pwdata[3:0] != 4'h0 && pwdata[3:0] <= 4'(NUM_SPANS)) span_num_d = pwdata[3:0];
            OFS_REF_WT: ref_wt_d = pwdata;
            OFS_LIMITS: begin
               max_d = pwdata[LIM_MAX_LSB +: LIM_W];
               high_d = pwdata[LIM_HIGH_LSB +: LIM_W];
               low_d = pwdata[LIM_LOW_LSB +: LIM_W];
            end
            OFS_MA_CAL: begin
               ma_lo_d = pwdata[15:0];
               ma_hi_d = pwdata[MA_HI_LSB +: 16];
            end
            OFS_MA_FUNC: ma_func_d = pwdata[2*NUM_MA-1:0];
            OFS_RELAY_FUNC: relay_func_d = pwdata[4*NUM_RELAYS-1:0];
            OFS_RELAY_POL: relay_pol_d = pwdata[NUM_RELAYS-1:0];
            OFS_LIN_GAIN: lin_gain_d = pwdata;
            default: ;
         endcase
      end
      case (state_q)
         S_IDLE: if (act_req && enable_q) state_d = S_FILL;
         S_FILL: if (level_q >= 16'(max_q)) begin
            relay_on_d = 1'b1;
            state_d = S_WAIT_HIGH;
         end
         S_WAIT_HIGH: if (level_q <= 16'(high_q)) begin
            total_d = '0;
            state_d = S_TOTAL;
         end
         S_TOTAL: begin
            // Sample at the low threshold is left out so the total is frozen there
            if (level_q <= 16'(low_q)) begin
               relay_on_d = 1'b0;
               dev_neg_d = total_q < ref_wt_q;
               state_d = S_DIV_DEV;
            end else if (rate_valid) begin
               total_d = total_q + rate_d;
            end
         end
         S_DIV_DEV: if (div_done && tag_q == T_DEV) begin
            dev_d = div_quo[15:0];
            state_d = S_DIV_SPAN;
         end
         S_DIV_SPAN: if (div_done && tag_q == T_SPAN) begin
            new_span_d = div_quo[15:0];
            state_d = S_RESULT;
         end
         S_RESULT: begin
            oor_d = oor_calc;
            if (accept_req && !oor_calc) begin
               span_tab_d[span_idx] = new_span_q;
               span_done_d = 1'b1;
               state_d = S_IDLE;
            end else if (run_req) state_d = S_IDLE;
            else if (cmd_rearm) state_d = S_FILL;
         end
         default: state_d = S_IDLE;
      endcase
      // Clearing the enable aborts the check and frees the infeed
      if (!enable_q) begin
         state_d = S_IDLE;
         relay_on_d = 1'b0;
      end
      if (state_d != S_RESULT) oor_d = 1'b0;
   end

   // Relay drive with per-relay polarity
   logic [NUM_RELAYS-1:0] relay_d;
   generate
      for (g = 0; g < NUM_RELAYS; g++) begin : g_rly
         assign relay_d[g] = (relay_on_q && relay_func_q[4*g +: 4] == RELAY_FUNC_ONLINE) ^ relay_pol_q[g];
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable_q <= 1'b0;
         aux_func_q <= '0;
         span_num_q <= SPAN_NUM_RST;
         ref_wt_q <= '0;
         lin_gain_q <= LIN_UNITY;
         max_q <= MAX_RST;
         high_q <= HIGH_RST;
         low_q <= LOW_RST;
         ma_lo_q <= MA_LO_RST;
         ma_hi_q <= MA_HI_RST;
         ma_func_q <= '0;
         relay_func_q <= '0;
         relay_pol_q <= '0;
         for (int i = 0; i < NUM_SPANS; i++) begin
            span_tab_q[i] <= SPAN_RST;
            init_tab_q[i] <= SPAN_RST;
         end
         span_done_q <= 1'b0;
         state_q <= S_IDLE;
         tag_q <= T_LEVEL;
         total_q <= '0;
         dev_q <= '0;
         dev_neg_q <= 1'b0;
         new_span_q <= '0;
         level_q <= '0;
         oor_q <= 1'b0;
         relay_on_q <= 1'b0;
         prdata_q <= '0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         rate_q <= '0;
         rate_v_q <= 1'b0;
         relay_out <= '0;
      end else begin
         enable_q <= enable_d;
         aux_func_q <= aux_func_d;
         span_num_q <= span_num_d;
         ref_wt_q <= ref_wt_d;
         lin_gain_q <= lin_gain_d;
         max_q <= max_d;
         high_q <= high_d;
         low_q <= low_d;
         ma_lo_q <= ma_lo_d;
         ma_hi_q <= ma_hi_d;
         ma_func_q <= ma_func_d;
         relay_func_q <= relay_func_d;
         relay_pol_q <= relay_pol_d;
         span_tab_q <= span_tab_d;
         init_tab_q <= init_tab_d;
         span_done_q <= span_done_d;
         state_q <= state_d;
         tag_q <= tag_d;
         total_q <= total_d;
         dev_q <= dev_d;
         dev_neg_q <= dev_neg_d;
         new_span_q <= new_span_d;
         level_q <= level_d;
         oor_q <= oor_d;
         relay_on_q <= relay_on_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         rate_q <= rate_d;
         rate_v_q <= rate_valid;
         relay_out <= relay_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign rate_out = rate_q;
   assign rate_out_valid = rate_v_q;

   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence low_reached;
      state_q == S_TOTAL && level_q <= 16'(low_q) && enable_q;
   endsequence
   sequence eval_entered;
      low_reached ##1 state_q == S_DIV_DEV;
   endsequence
   remote_priority_a: assert property (span_done_q && aux_func_q[3:0] == AUX_SPAN_SEL |-> span_idx[0] == filt_q[0]) else $error("remote span not used");
   remote_lock_a: assert property (!span_done_q |-> span_cur == span_tab_q[3'(span_num_q - 4'h1)]) else $error("remote span before cal");
   enable_gate_a: assert property (state_q == S_IDLE && !enable_q |=> state_q == S_IDLE) else $error("activated while off");
   relay_max_a: assert property (state_q == S_FILL && level_q >= 16'(max_q) && enable_q |=> relay_on_q ##1 (relay_out == relay_d)) else $error("relay not set at max");
   total_start_a: assert property (state_q == S_WAIT_HIGH && level_q <= 16'(high_q) && enable_q |=> state_q == S_TOTAL && total_q == 32'h0) else $error("totalizer not started");
   relay_low_a: assert property (low_reached |=> !relay_on_q && $stable(total_q)) else $error("relay held past low");
   eval_bound_a: assert property (eval_entered |-> ##[1:300] (state_q == S_RESULT || state_q == S_IDLE)) else $error("evaluation too slow");
   refuse_range_a: assert property (state_q == S_RESULT && oor_calc && !run_req && !cmd_rearm && enable_q |=> state_q == S_RESULT && $stable(span_tab_q[span_idx])) else $error("out of range accepted");
   relay_pin_a: assert property (relay_on_q && relay_func_q[3:0] == RELAY_FUNC_ONLINE |=> relay_out[0] == !relay_pol_q[0] || $changed(relay_pol_q)) else $error("relay pin wrong");
endmodule : span_calibrator
`default_nettype wire

// file: verif/bin_model.sv
// Weigh bin level transmitter gated by the feed-stop relay
`timescale 1ns/10ps
`default_nettype none
module bin_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic feed_stop,
   output logic [15:0] ma
);
   // Fills while feed runs, drains while stopped; a step of 8 counts per clock keeps the run short
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ma <= 16'h0000;
      end else if (feed_stop) begin
         ma <= (ma > 16'h0008) ? ma - 16'h0008 : 16'h0000;
      end else begin
         ma <= (ma < 16'hFFF0) ? ma + 16'h0008 : ma;
      end
   end
endmodule : bin_model
`default_nettype wire

// file: verif/span_calibrator_tb_top.sv
// Self-checking bench for the span calibrator
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin miscompares++; \
   $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module span_calibrator_tb_top;
   import span_cal_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err, rate_out_valid;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, rate_out;
   logic [4:0] aux_in = 5'h00, relay_out;
   logic [15:0] ma0;
   int miscompares = 0, check_count = 0;
   span_calibrator i_span_calibrator (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .aux_in, .ma_in_0(ma0), .ma_in_1(16'h0000), .rate_in(16'h0100), .rate_valid(1'b1),
      .rate_out, .rate_out_valid, .relay_out);
   bin_model i_bin_model (.pclk, .presetn, .feed_stop(relay_out[0]), .ma(ma0));
   // Clock, 25 ns period
   initial begin
      forever #12.5 pclk = ~pclk;
   end
   // One APB transfer; values read right after an edge are those sampled at it
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata; err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic waitst(input cal_state_type s);
      int n;
      n = 0;
      do apb(1'b0, OFS_STATUS, 32'h0); while (rd[2:0] !== s && ++n < 9000);
      `CHK(rd[2:0], s)
   endtask : waitst
   task automatic t_reset;
      apb(1'b0, OFS_SPAN_SEL, 32'h0); `CHK(rd[3:0], 4'h1)
      apb(1'b0, OFS_LIMITS, 32'h0); `CHK(rd[29:0], {10'h12C, 10'h2BC, 10'h384})
      apb(1'b0, 12'h0FC, 32'h0); `CHK(err, 1'b1)
   endtask : t_reset
   // Span 1 count is 0x8000, span k set to k<<12, so rate_out is k<<5
   task automatic t_select;
      apb(1'b1, OFS_AUX_FUNC, 32'h111); aux_in <= 5'h01; repeat (10) @(posedge pclk);
      `CHK(rate_out, 32'h100)
      for (int k = 0; k < 8; k++) apb(1'b1, 12'(OFS_SPAN_BASE + 4 * k), 32'((k + 1) << 12));
      apb(1'b1, OFS_SPAN_SEL, 32'h3); repeat (10) @(posedge pclk);
      `CHK(rate_out, 32'h40)
      for (int i = 0; i < 8; i++) begin
         aux_in <= 5'(i); repeat (10) @(posedge pclk);
         `CHK(rate_out, 32'((i + 1) << 5))
      end
      apb(1'b1, OFS_LIN_GAIN, 32'h0002_0000); repeat (10) @(posedge pclk);
      `CHK(rate_out, 32'h200)
      `CHK(rate_out_valid, 1'b1)
      apb(1'b1, OFS_LIN_GAIN, LIN_UNITY);
      apb(1'b1, OFS_AUX_FUNC, 32'h1); aux_in <= 5'h07; repeat (10) @(posedge pclk);
      `CHK(rate_out, 32'h40)
      apb(1'b1, OFS_AUX_FUNC, 32'h0); aux_in <= 5'h00;
   endtask : t_select
   // Huge reference weight forces a result far outside the accepted band
   task automatic t_online;
      longint t1, t2, ns;
      apb(1'b1, OFS_MA_FUNC, 32'h3); apb(1'b1, OFS_RELAY_FUNC, 32'h9); apb(1'b1, OFS_REF_WT, 32'hFFFF_FFFF);
      apb(1'b1, OFS_RELAY_POL, 32'h2); apb(1'b1, OFS_AUX_FUNC, 32'h0003_2040);
      apb(1'b1, OFS_CMD, 32'h1); apb(1'b0, OFS_STATUS, 32'h0); `CHK(rd[2:0], S_IDLE)
      `CHK(relay_out, 5'h02)
      apb(1'b1, OFS_CTRL, 32'h1); apb(1'b1, OFS_CMD, 32'h1);
      waitst(S_WAIT_HIGH); `CHK(relay_out, 5'h03)
      waitst(S_RESULT); `CHK(relay_out, 5'h02)
      apb(1'b1, OFS_CMD, 32'h2); apb(1'b0, OFS_STATUS, 32'h0); `CHK(rd[3:0], {1'b1, S_RESULT})
      apb(1'b0, 12'h048, 32'h0); `CHK(rd, 32'h3000)
      // Second pass: reference is the first total, so the result lands close to span 3
      apb(1'b0, OFS_TOTAL, 32'h0); t1 = rd; apb(1'b1, OFS_REF_WT, rd);
      apb(1'b1, OFS_CMD, 32'h8); apb(1'b0, OFS_STATUS, 32'h0); `CHK(rd[2:0], S_FILL)
      waitst(S_RESULT);
      apb(1'b0, OFS_TOTAL, 32'h0); t2 = rd; ns = (t2 * 16'h3000) / t1;
      apb(1'b0, OFS_DEVIATION, 32'h0); `CHK(rd, {t2 < t1, 15'h0, 16'((((t2 > t1) ? t2 - t1 : t1 - t2) * 1000) / t1)})
      apb(1'b0, OFS_NEW_SPAN, 32'h0); `CHK(rd, 32'(ns))
      aux_in <= 5'h10; waitst(S_IDLE); aux_in <= 5'h00;
      apb(1'b0, 12'h048, 32'h0); `CHK(rd, 32'(ns))
      // Third pass: contacts start the check and return to run
      aux_in <= 5'h08; waitst(S_FILL); aux_in <= 5'h00;
      waitst(S_RESULT);
      aux_in <= 5'h02; waitst(S_IDLE); aux_in <= 5'h00;
   endtask : t_online
   task automatic print_verdict;
      if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : print_verdict
   // Main sequence after 5 cycles of reset
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset;
      t_select;
      t_online;
      print_verdict;
   end
   // Watchdog, well beyond the expected run
   initial begin
      repeat (60000) @(posedge pclk);
      miscompares++;
      print_verdict;
   end
endmodule : span_calibrator_tb_top
`default_nettype wire
